// file: rtl/fspg_top.sv
// Frame sync phase pulse generator with serial clock divider and AXI4-Lite registers
// Function
// RQ1 - Phase is 20 bits: upper ten from fs control, lower ten from clock control.
// RQ2 - Both phase halves sit in bits 29 to 20 of their control words.
// RQ3 - Frame sync divisor is bits 19 to 0 of fs control word.
// RQ4 - Software uses one source and fs divisor a multiple of clock divisor.
// RQ5 - Software enables and disables clock and frame sync in one write.
// RQ6 - Phase zero: rise together; phase N: frame sync N input periods earlier; the code raises frame sync N input periods after the clock.
// RQ7 - Zero phase, equal divisors, shared source, joint enable: positive edges align.
// RQ8 - On enable, fs divider starts as if divisor minus phase cycles elapsed.
// RQ9 - Normal mode: frame sync high for programmed 16-bit count of periods.
// RQ10 - High count is read from the pulse width word fields.
// RQ11 - Zero count gives high time of divisor halved, rounded down.
// RQ12 - Divisor other than zero or one: normal divider, output is input over divisor.
// RQ13 - Bypass uses bits 1-0 as one-shot select, 17-16 as invert.
// RQ14 - Bypass without one-shot passes input through, optionally inverted.
// RQ15 - Bypass with one-shot emits one pulse one strobe period wide.
// RQ16 - Pulse starts on second strobe rise after clock rise, or fall if inverted.
// RQ17 - External trigger armed only when sync bits 0 and 16 are set.
// RQ18 - Armed trigger holds outputs off until a rising trigger edge.
// RQ19 - Outputs start three input periods after the trigger edge.
// RQ20 - For I2S software sets phase to half the clock divisor.
// RQ21 - Everything runs on the peripheral clock, sampling inputs in that domain.
`timescale 1ns/1ps
module fspg_top import fspg_pkg::*; #(
    parameter int DIV_WIDTH = DIV_W,
    parameter int PW_WIDTH = PW_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic crystal_clock_input,
    input wire logic routed_clock_input,
    input wire logic strobe_source_input,
    input wire logic ext_trigger_input,
    output logic serial_clock_out,
    output logic fs_out
);

    // Field widths are tied to the register layout
    if (DIV_WIDTH != DIV_W || PW_WIDTH != PW_W) begin : g_bad_width
        $error("Field widths are fixed by the register layout");
    end

    fspg_state_t s_q;
    fspg_state_t s_d;

    logic pclk_sel;
    logic clk_en;
    logic fs_en;
    logic [DIV_W-1:0] clk_div;
    logic [DIV_W-1:0] fs_div;
    logic [DIV_W-1:0] phase;
    logic [DIV_W-1:0] width;
    logic [DIV_W-1:0] fs_start;
    logic clk_byp;
    logic fs_byp;
    logic one_shot_select;
    logic fs_invert;
    logic trig_armed;
    logic clk_lvl;
    logic clk_rise;
    logic fs_lvl;
    logic fs_tick;
    logic fs_rise;
    logic fs_fall;
    logic stb_rise;
    logic trg_rise;
    logic go;
    logic os_active;
    logic os_edge;
    logic [DIV_W-1:0] cc_n;
    logic [DIV_W-1:0] fc_n;
    logic wr_fire;
    logic [31:0] rd_val;
    logic rd_ok;

    // Byte lanes merged one by one
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        s_d = s_q;

        // Control fields
        pclk_sel = s_q.sync[SYNC_PCLK];
        clk_en = s_q.clk_ctl[EN_BIT];
        fs_en = s_q.fs_ctl[EN_BIT];
        clk_div = s_q.clk_ctl[DIV_LSB +: DIV_W];
        fs_div = s_q.fs_ctl[DIV_LSB +: DIV_W]; // see RQ3
        phase = {s_q.fs_ctl[PH_LSB +: PH_W], s_q.clk_ctl[PH_LSB +: PH_W]}; // see RQ1 see RQ2
        width = {{(DIV_W-PW_W){1'b0}}, s_q.width[PW_LSB +: PW_W]}; // see RQ10
        if (width == '0) begin
            width = fs_div >> 1; // see RQ11
        end
        clk_byp = clk_div < 20'h00002;
        fs_byp = fs_div < 20'h00002; // see RQ12
        one_shot_select = s_q.width[STB_LSB +: 2] != 2'h0; // see RQ13
        fs_invert = s_q.width[INV_LSB +: 2] != 2'h0; // see RQ13
        trig_armed = s_q.sync[SYNC_ARM_A] & s_q.sync[SYNC_ARM_B]; // see RQ17

        // Three-stage sampling; a level counts once stages two and three agree
        s_d.pipe.xtal = {s_q.pipe.xtal[1:0], crystal_clock_input}; // see RQ21
        s_d.pipe.pin = {s_q.pipe.pin[1:0], routed_clock_input};
        s_d.pipe.stb = {s_q.pipe.stb[1:0], strobe_source_input};
        s_d.pipe.trg = {s_q.pipe.trg[1:0], ext_trigger_input};
        if (s_q.pipe.xtal[1] == s_q.pipe.xtal[2]) begin
            s_d.xtal_st = s_q.pipe.xtal[2];
        end
        if (s_q.pipe.pin[1] == s_q.pipe.pin[2]) begin
            s_d.pin_st = s_q.pipe.pin[2];
        end
        if (s_q.pipe.stb[1] == s_q.pipe.stb[2]) begin
            s_d.stb_st = s_q.pipe.stb[2];
        end
        if (s_q.pipe.trg[1] == s_q.pipe.trg[2]) begin
            s_d.trg_st = s_q.pipe.trg[2];
        end
        s_d.tog = ~s_q.tog;
        stb_rise = s_d.stb_st & ~s_q.stb_st;
        trg_rise = s_d.trg_st & ~s_q.trg_st;

        // Peripheral clock source ticks every cycle, shown as a half-rate level
        if (pclk_sel) begin
            clk_lvl = s_q.tog;
            clk_rise = 1'b1;
            fs_lvl = s_q.tog;
            fs_rise = 1'b1;
            fs_fall = 1'b1;
        end else begin
            clk_lvl = s_q.clk_ctl[SRC_PIN_BIT] ? s_d.pin_st : s_d.xtal_st;
            clk_rise = s_q.clk_ctl[SRC_PIN_BIT] ? (s_d.pin_st & ~s_q.pin_st)
                                                : (s_d.xtal_st & ~s_q.xtal_st);
            fs_lvl = s_q.fs_ctl[SRC_PIN_BIT] ? s_d.pin_st : s_d.xtal_st;
            fs_rise = s_q.fs_ctl[SRC_PIN_BIT] ? (s_d.pin_st & ~s_q.pin_st)
                                              : (s_d.xtal_st & ~s_q.xtal_st);
            fs_fall = s_q.fs_ctl[SRC_PIN_BIT] ? (~s_d.pin_st & s_q.pin_st)
                                              : (~s_d.xtal_st & s_q.xtal_st);
        end
        fs_tick = fs_rise;

        // Divider starts as though divisor minus phase periods already passed
        if (phase == '0 || phase >= fs_div) begin
            fs_start = '0;
        end else begin
            fs_start = fs_div - phase; // see RQ8 see RQ6
        end

        // Run control shared by clock and frame sync
        go = clk_en | fs_en;
        cc_n = s_q.cc;
        fc_n = s_q.fc;
        case (s_q.run)
            RUN_OFF: begin
                if (go) begin
                    cc_n = '0;
                    fc_n = fs_start; // see RQ7
                    if (trig_armed) begin
                        s_d.run = RUN_WAIT_TRIG; // see RQ18
                    end else begin
                        s_d.run = RUN_ON;
                    end
                end
            end
            RUN_WAIT_TRIG: begin
                if (trg_rise) begin
                    s_d.run = RUN_DELAY;
                    s_d.dly = 2'h0;
                end
            end
            RUN_DELAY: begin
                if (clk_rise) begin
                    s_d.dly = s_q.dly + 2'h1;
                    if (s_q.dly == TRIG_DELAY - 2'h1) begin
                        s_d.run = RUN_ON; // see RQ19
                        cc_n = '0;
                        fc_n = fs_start;
                    end
                end
            end
            RUN_ON: begin
                if (clk_rise) begin
                    cc_n = (s_q.cc >= clk_div - 20'h00001) ? '0 : s_q.cc + 20'h00001;
                end
                if (fs_tick) begin
                    fc_n = (s_q.fc >= fs_div - 20'h00001) ? '0 : s_q.fc + 20'h00001;
                end
            end
            default: begin
                s_d.run = RUN_OFF;
            end
        endcase
        if (!go) begin
            s_d.run = RUN_OFF;
        end
        s_d.cc = cc_n;
        s_d.fc = fc_n;

        // One-shot strobe: second strobe rise after the chosen clock edge
        os_active = fs_en && fs_byp && one_shot_select && s_q.run == RUN_ON;
        os_edge = fs_invert ? fs_fall : fs_rise; // see RQ16
        s_d.os_n = s_q.os_n;
        case (s_q.os)
            OS_IDLE: begin
                if (os_active && os_edge) begin
                    s_d.os = OS_SEEK;
                    s_d.os_n = stb_rise;
                end
            end
            OS_SEEK: begin
                if (stb_rise) begin
                    if (s_q.os_n) begin
                        s_d.os = OS_PULSE; // see RQ16
                    end else begin
                        s_d.os_n = 1'b1;
                    end
                end
            end
            OS_PULSE: begin
                if (stb_rise) begin
                    s_d.os = OS_DONE; // see RQ15
                end
            end
            OS_DONE: begin
                s_d.os = OS_DONE;
            end
            default: begin
                s_d.os = OS_IDLE;
            end
        endcase
        if (!os_active) begin
            s_d.os = OS_IDLE;
        end

        // Outputs come from the next counter values so they leave flip-flops
        if (s_d.run != RUN_ON || !clk_en) begin
            s_d.clk_out = 1'b0;
        end else if (clk_byp) begin
            s_d.clk_out = clk_lvl;
        end else begin
            s_d.clk_out = cc_n < (clk_div >> 1);
        end
        if (s_d.run != RUN_ON || !fs_en) begin
            s_d.fs_out = 1'b0; // see RQ18
        end else if (fs_byp && one_shot_select) begin
            s_d.fs_out = s_d.os == OS_PULSE; // see RQ15
        end else if (fs_byp) begin
            s_d.fs_out = fs_lvl ^ fs_invert; // see RQ14
        end else begin
            s_d.fs_out = fc_n < width; // see RQ9 see RQ12
        end

        // AXI4-Lite write: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        if (wr_fire) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            // Dividers share one run state, so staggered enables stay in step
            case ({s_q.awaddr[7:2], 2'b00})
                OFF_FS_CTL: s_d.fs_ctl = merge(s_q.fs_ctl, s_q.wdata, s_q.wstrb);
                OFF_CLK_CTL: s_d.clk_ctl = merge(s_q.clk_ctl, s_q.wdata, s_q.wstrb);
                OFF_WIDTH: s_d.width = merge(s_q.width, s_q.wdata, s_q.wstrb);
                OFF_SYNC: s_d.sync = merge(s_q.sync, s_q.wdata, s_q.wstrb);
                OFF_STATUS: s_d.bresp = RESP_OKAY;
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // AXI4-Lite read
        rd_ok = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            OFF_FS_CTL: rd_val = s_q.fs_ctl;
            OFF_CLK_CTL: rd_val = s_q.clk_ctl;
            OFF_WIDTH: rd_val = s_q.width;
            OFF_SYNC: rd_val = s_q.sync;
            OFF_STATUS: rd_val = {25'h0000000, s_q.os, s_q.run,
                                  trig_armed, s_q.fs_out, s_q.clk_out};
            default: begin
                rd_val = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_val;
            s_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.fs_ctl <= REG_RESET;
            s_q.clk_ctl <= REG_RESET;
            s_q.width <= REG_RESET;
            s_q.sync <= REG_RESET;
            s_q.run <= RUN_OFF;
            s_q.os <= OS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Handshakes stay combinational; one write and one read in flight
    assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_have && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign serial_clock_out = s_q.clk_out;
    assign fs_out = s_q.fs_out;

endmodule

// file: rtl/fspg_pkg.sv
// Package with constants and types of the frame sync phase pulse generator
package fspg_pkg;

    localparam int DIV_W = 20;
    localparam int PH_W = 10;
    localparam int PW_W = 16;

    localparam logic [7:0] OFF_FS_CTL = 8'h00;
    localparam logic [7:0] OFF_CLK_CTL = 8'h04;
    localparam logic [7:0] OFF_WIDTH = 8'h08;
    localparam logic [7:0] OFF_SYNC = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    localparam int EN_BIT = 31;
    localparam int SRC_PIN_BIT = 30;
    localparam int PH_LSB = 20;
    localparam int DIV_LSB = 0;
    localparam int PW_LSB = 0;
    localparam int STB_LSB = 0;
    localparam int INV_LSB = 16;
    localparam int SYNC_ARM_A = 0;
    localparam int SYNC_ARM_B = 16;
    localparam int SYNC_PCLK = 8;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [1:0] TRIG_DELAY = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RUN_OFF = 2'b00,
        RUN_WAIT_TRIG = 2'b01,
        RUN_DELAY = 2'b10,
        RUN_ON = 2'b11
    } fspg_run_t;

    typedef enum logic [1:0] {
        OS_IDLE = 2'b00,
        OS_SEEK = 2'b01,
        OS_PULSE = 2'b10,
        OS_DONE = 2'b11
    } fspg_os_t;

    typedef struct packed {
        logic [2:0] xtal;
        logic [2:0] pin;
        logic [2:0] stb;
        logic [2:0] trg;
    } fspg_sync_t;

    typedef struct packed {
        logic [31:0] fs_ctl;
        logic [31:0] clk_ctl;
        logic [31:0] width;
        logic [31:0] sync;
        fspg_sync_t pipe;
        logic xtal_st;
        logic pin_st;
        logic stb_st;
        logic trg_st;
        logic tog;
        fspg_run_t run;
        logic [1:0] dly;
        logic [DIV_W-1:0] cc;
        logic [DIV_W-1:0] fc;
        fspg_os_t os;
        logic os_n;
        logic clk_out;
        logic fs_out;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fspg_state_t;

endpackage

// file: verif/fspg_top_asserts.sv
// Register port checker for the frame sync generator
`timescale 1ns/1ps
module fspg_top_asserts import fspg_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_read_answer: assert property (read_taken |=> s_axi_rvalid)
        else $error("read response late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    a_unmapped_read: assert property (read_taken ##0 (s_axi_araddr[7:2] > 6'h04) |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
    a_mapped_read: assert property (read_taken ##0 (s_axi_araddr[7:2] <= 6'h04) |=>
        s_axi_rresp == RESP_OKAY) else $error("bad mapped read");
endmodule
bind fspg_top fspg_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

// file: verif/fspg_far_end.sv
// Far side model: routed clock, crystal, strobe source and trigger
`timescale 1ns/1ps
module fspg_far_end #(
    parameter int SRC_HI = 2,
    parameter int SRC_PER = 6,
    parameter int STB_PER = 10
) (
    input wire logic aclk,
    input wire logic trig_req,
    output logic routed_clock_input,
    output logic crystal_clock_input,
    output logic strobe_source_input,
    output logic ext_trigger_input
);
    int src_cnt = 0;
    int stb_cnt = 0;
    initial begin
        routed_clock_input = 1'b0;
        crystal_clock_input = 1'b0;
        strobe_source_input = 1'b0;
        ext_trigger_input = 1'b0;
    end
    // Uneven duty so an inverted bypass is told apart
    always @(posedge aclk) begin
        src_cnt <= (src_cnt + 1) % SRC_PER;
        stb_cnt <= (stb_cnt + 1) % STB_PER;
        routed_clock_input <= (src_cnt < SRC_HI);
        crystal_clock_input <= (src_cnt < SRC_PER / 2);
        strobe_source_input <= (stb_cnt < STB_PER / 2);
        if (src_cnt == 0) begin
            ext_trigger_input <= trig_req;
        end
    end
endmodule

// file: verif/fspg_tb_top.sv
// Self-checking bench for the frame sync phase pulse generator
`timescale 1ns/1ps
module fspg_tb_top import fspg_pkg::*;;
    localparam int P = 6;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, trig_req = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, rv;
    logic awr, wr_rdy, bv, arr, rvl, sck, fso, rclk, xclk, stb, trg;
    logic [1:0] bresp, rresp, rs;
    int n_errors = 0, checked = 0, cyc = 0;
    int fs_r_t = 0, fs_f_t = 0, fs_rises = 0, ck_first = 0, fs_first = 0, trg_t = 0;
    logic fs_p = 1'b0, ck_p = 1'b0, tr_p = 1'b0;
    always #2.5 aclk = ~aclk;
    fspg_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvl), .s_axi_rready(rrdy), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .crystal_clock_input(xclk), .routed_clock_input(rclk),
        .strobe_source_input(stb), .ext_trigger_input(trg), .serial_clock_out(sck),
        .fs_out(fso));
    fspg_far_end u_far (.aclk(aclk), .trig_req(trig_req), .routed_clock_input(rclk),
        .crystal_clock_input(xclk), .strobe_source_input(stb), .ext_trigger_input(trg));
    // Edge timestamps; first rises are taken relative to the last trigger
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        fs_p <= fso;
        ck_p <= sck;
        tr_p <= trg;
        if (fso && !fs_p) begin
            fs_r_t <= cyc;
            fs_rises <= fs_rises + 1;
            if (fs_first <= trg_t) begin
                fs_first <= cyc;
            end
        end
        if (!fso && fs_p) begin
            fs_f_t <= cyc;
        end
        if (sck && !ck_p && ck_first <= trg_t) begin
            ck_first <= cyc;
        end
        if (trg && !tr_p) begin
            trg_t <= cyc;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        brdy <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
        end while (!bv);
        r = bresp;
        brdy <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        arv <= 1'b1;
        ara <= a;
        rrdy <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rvl);
        d = rdat;
        r = rresp;
        rrdy <= 1'b0;
    endtask
    task automatic stop();
        wr(OFF_FS_CTL, 32'h0, rs);
        wr(OFF_CLK_CTL, 32'h0, rs);
    endtask
    task automatic wait_chg(ref int v);
        int o;
        o = v;
        while (v == o) @(posedge aclk);
    endtask
    task automatic meas(output int hi, output int per);
        int r0;
        // First pulse after enable is cut short, so skip it
        wait_chg(fs_rises);
        wait_chg(fs_rises);
        r0 = fs_r_t;
        wait_chg(fs_f_t);
        hi = fs_f_t - fs_r_t;
        wait_chg(fs_rises);
        per = fs_r_t - r0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        finish_test();
    end
    initial begin
        int hi, per, d, n, k, m;
        logic [31:0] v;
        void'($urandom(32'h7610A635));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_WIDTH, v, rs);
        chk(v, REG_RESET);
        v = $urandom();
        wr(OFF_WIDTH, v, rs);
        rd(OFF_WIDTH, rv, rs);
        chk(rv, v);
        wr(8'h40, v, rs);
        chk(32'(rs), 32'(RESP_SLVERR));
        rd(8'h40, rv, rs);
        chk(rv, 32'h0);
        wr(OFF_STATUS, v, rs);
        chk(32'(rs), 32'(RESP_OKAY));
        $display("test registers done");
        for (k = 0; k < 3; k++) begin
            v = (k == 0) ? 32'h0000_0001 : (k == 1) ? 32'h0001_0000 : 32'h0001_0001;
            wr(OFF_SYNC, v, rs);
            rd(OFF_STATUS, rv, rs);
            chk(32'(rv[2]), 32'(k == 2));
        end
        wr(OFF_SYNC, 32'h0, rs);
        $display("test arming done");
        for (k = 0; k < 5; k++) begin
            d = (k == 0) ? 2 : (k == 1) ? 7 : $urandom_range(24, 2);
            n = (k < 2) ? 0 : $urandom_range(d - 1, 0);
            m = (k == 3) ? 1 : P;
            wr(OFF_SYNC, 32'(k == 3) << SYNC_PCLK, rs);
            wr(OFF_WIDTH, 32'(n), rs);
            wr(OFF_FS_CTL, ((k == 4) ? 32'h8000_0000 : 32'hC000_0000) | 32'(d), rs);
            meas(hi, per);
            chk(32'(hi), 32'((n == 0 ? d / 2 : n) * m));
            chk(32'(per), 32'(d * m));
            stop();
        end
        $display("test normal done");
        for (k = 0; k < 4; k++) begin
            v = ($urandom() & 32'hFFFC_FFFC) | (32'(k) << 16);
            wr(OFF_WIDTH, v, rs);
            wr(OFF_FS_CTL, 32'hC000_0000 | 32'(k & 1), rs);
            meas(hi, per);
            chk(32'(hi), (k != 0) ? 32'h4 : 32'h2);
            chk(32'(per), 32'(P));
            stop();
        end
        $display("test bypass done");
        for (k = 0; k < 2; k++) begin
            wr(OFF_WIDTH, ($urandom() & 32'hFFFC_FFFC) | 32'(k + 1) | (32'(k) << 16), rs);
            n = fs_rises;
            wr(OFF_FS_CTL, 32'hC000_0000, rs);
            repeat (200) @(posedge aclk);
            chk(32'(fs_rises - n), 32'h1);
            chk(32'(fs_f_t - fs_r_t), 32'hA);
            stop();
        end
        $display("test one-shot done");
        // Armed start lines both dividers up without a single enabling write
        wr(OFF_SYNC, 32'h0001_0001, rs);
        for (k = 0; k < 4; k++) begin
            // Phase kept at zero or where the pulse starts low, so its first rise is measurable
            d = (k == 3) ? 2060 : 16;
            n = (k == 0) ? 0 : (k == 1) ? 2 : (k == 2) ? $urandom_range(8, 1) : 1027;
            trig_req <= 1'b0;
            wr(OFF_WIDTH, 32'h0, rs);
            wr(OFF_CLK_CTL, 32'hC000_0004 | (32'(n % 1024) << 20), rs);
            wr(OFF_FS_CTL, 32'hC000_0000 | (32'(n / 1024) << 20) | 32'(d), rs);
            v = 32'(fs_rises);
            repeat (60) @(posedge aclk);
            chk(32'(fs_rises), v);
            trig_req <= 1'b1;
            wait (trg === 1'b1);
            repeat (2) @(posedge aclk);
            while (fs_first <= trg_t || ck_first <= trg_t) @(posedge aclk);
            chk(32'(ck_first - trg_t >= 3 * P && ck_first - trg_t <= 3 * P + 6), 32'h1);
            chk(32'(fs_first - ck_first), 32'(n * P));
            stop();
        end
        $display("test phase done");
        finish_test();
    end
endmodule
